// *** rtl/ats_pkg.sv ***
package ats_pkg;

    // Clocking and converter clock limits
    localparam int SYS_CLK_HZ     = 250_000_000;
    localparam int CLK_PERIOD_NS  = 4;
    localparam int ADC_CLK_MAX_HZ = 10_000_000;
    localparam int ADC_DIV_STEP   = 4;
    localparam int ADC_DIV_MIN    = ((SYS_CLK_HZ / ADC_CLK_MAX_HZ) / ADC_DIV_STEP) * ADC_DIV_STEP + ADC_DIV_STEP;

    // Prescaler settling time and its least cycle count
    localparam int SETTLE_TIME_NS = 10_000;
    localparam int SETTLE_CYC     = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Threshold arithmetic
    localparam int          CODE_W        = 12;
    localparam int          CODE_LOG2     = 12;
    localparam int          CODE_LEVELS   = 4096;
    localparam logic [11:0] CODE_FULL     = 12'hFFF;
    localparam int          SF_NUM        = 5;
    localparam int          SF_DEN_LOG2   = 5;
    localparam int          CUR_GAIN      = 10;
    localparam int          MV_PER_V      = 1000;
    localparam int          TEMP_Q_LOG2   = 16;
    localparam real         DIODE_A       = 2.30258;
    localparam real         DIODE_B       = 0.0000087248;
    localparam real         TEMP_GAIN     = 12.5;
    localparam int          TEMP_KG_Q16   = int'(DIODE_A * DIODE_B * TEMP_GAIN * 1000.0 * 65536.0);
    localparam int          NUM_W         = 48;
    localparam int          DEN_W         = 32;

    // Prescaler ranges: index 0 is the 16 V range, each step halves the range
    localparam int          RANGE_TOP_MV  = 16000;
    localparam int          RANGE_CNT     = 8;
    localparam logic [2:0]  RANGE_4V      = 3'h2;
    localparam logic [2:0]  RANGE_16V     = 3'h0;

    // Register offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_USER_THR  = 8'h04;
    localparam logic [7:0] OFS_RESISTOR  = 8'h08;
    localparam logic [7:0] OFS_VREF      = 8'h0C;
    localparam logic [7:0] OFS_VMAX      = 8'h10;
    localparam logic [7:0] OFS_ACQ       = 8'h14;
    localparam logic [7:0] OFS_STATUS    = 8'h18;
    localparam logic [7:0] OFS_THRESHOLD = 8'h1C;
    localparam logic [7:0] OFS_ADC_DIV   = 8'h20;
    localparam logic [7:0] OFS_RAW       = 8'h24;

    // Control field positions
    localparam int CTRL_START_BIT = 8;
    localparam int CTRL_DIV_LSB   = 12;

    // Reset values
    localparam logic [15:0] VREF_RST = 16'h0A00;
    localparam logic [15:0] VMAX_RST = 16'h3E80;
    localparam logic [15:0] ACQ_RST  = 16'h09C4;

    typedef enum logic [1:0] {
        ATS_MON_VOLT,
        ATS_MON_CURR,
        ATS_MON_DIFF,
        ATS_MON_TEMP
    } ats_mon_t;

    typedef enum logic [1:0] {
        ATS_RES_12,
        ATS_RES_10,
        ATS_RES_8,
        ATS_RES_RSVD
    } ats_res_t;

    typedef struct packed {
        logic [3:0] div_mult;
        logic [1:0] rsvd;
        logic       on_temp_pad;
        logic       neg_polarity;
        ats_res_t   res;
        ats_mon_t   mon;
    } ats_ctrl_t;

    localparam ats_ctrl_t CTRL_RST = '{div_mult: 4'h0, rsvd: 2'h0, on_temp_pad: 1'b0,
                                       neg_polarity: 1'b0, res: ATS_RES_12, mon: ATS_MON_VOLT};

endpackage : ats_pkg

// *** rtl/ats_threshold.sv ***
`timescale 1ns/1ps
// Function
// - One code step is the reference divided by 4096 and the arithmetic always runs at 12 bits.
// - A voltage threshold is the user voltage times the scaling factor of the chosen range over the code step.
// - A current or differential threshold is user current times resistor times a gain of ten over the code step.
// - A temperature threshold is kelvin times the diode constant 2.30258 x 0.0000087248 times a gain of 12.5.
// - A raw temperature result reads as kelvin at 4 K, 1 K or 0.25 K per step for 8, 10 or 12 bits.
// - The threshold is masked: nothing at 12 bits, bits 1:0 at 10 bits, bits 3:0 at 8 bits.
// - The prescaler range comes from the maximum input voltage, eight factors from 0.15625 to 20.0.
// - A maximum voltage above a range's nominal value selects the next higher range.
// - Negative polarity uses the same ranges and factors.
// - The converter clock uses dividers in steps of four and stays below 10 MHz.
// - A voltage monitor on a temperature_pad only gets the 4 V or 16 V range.
module ats_threshold
    import ats_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic      [11:0] threshold_code,
    output logic             threshold_valid,
    output logic      [2:0]  prescale_range,
    output logic             adc_clk_en
);

    typedef enum logic [2:0] {
        ATS_ST_IDLE,
        ATS_ST_PREP,
        ATS_ST_CHECK,
        ATS_ST_DIVIDE,
        ATS_ST_FINISH
    } ats_state_t;

    ats_ctrl_t          ctrl_reg;
    logic [23:0]        user_thr_reg;
    logic [15:0]        resistor_reg;
    logic [15:0]        vref_reg;
    logic [15:0]        vmax_reg;
    logic [15:0]        acq_reg;
    logic [11:0]        raw_reg;
    logic               start_reg;

    ats_state_t         state_reg;
    logic [NUM_W-1:0]   num_reg;
    logic [DEN_W-1:0]   den_reg;
    logic [NUM_W-1:0]   num_next;
    logic [DEN_W-1:0]   den_next;
    logic [11:0]        quot_reg;
    logic [3:0]         bit_reg;
    logic               sat_reg;
    logic               busy_reg;
    logic               done_reg;
    logic [NUM_W-1:0]   trial;
    logic               sat_hit;
    ats_res_t           res_hold_reg;

    logic [2:0]         range_reg;
    logic [2:0]         range_next;
    logic               over_reg;
    logic               over_next;
    logic [RANGE_CNT-1:0] fits_range;
    logic               acq_short_reg;

    logic [7:0]         div_eff_reg;
    logic [7:0]         div_cnt_reg;
    logic [7:0]         div_req;

    logic [13:0]        kelvin_q;

    // Code mask by resolution
    function automatic logic [11:0] ats_mask(input logic [11:0] code, input ats_res_t res);
        logic [11:0] m;
        m = code;
        case (res)
            ATS_RES_10: m[1:0] = 2'h0;
            ATS_RES_8:  m[3:0] = 4'h0;
            default:    m = code;
        endcase
        return m;
    endfunction : ats_mask

    // Register writes
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_reg     <= CTRL_RST;
            user_thr_reg <= 24'h000000;
            resistor_reg <= 16'h0000;
            vref_reg     <= VREF_RST;
            vmax_reg     <= VMAX_RST;
            acq_reg      <= ACQ_RST;
            raw_reg      <= 12'h000;
        end else begin
            if (reg_wr) begin
                case (reg_addr)
                    // Start and reserved bits are not stored
                    OFS_CTRL: begin
                        ctrl_reg.div_mult     <= reg_wdata[CTRL_DIV_LSB +: 4];
                        ctrl_reg.rsvd         <= 2'h0;
                        ctrl_reg.on_temp_pad  <= reg_wdata[5];
                        ctrl_reg.neg_polarity <= reg_wdata[4];
                        ctrl_reg.res          <= ats_res_t'(reg_wdata[3:2]);
                        ctrl_reg.mon          <= ats_mon_t'(reg_wdata[1:0]);
                    end
                    OFS_USER_THR: user_thr_reg <= reg_wdata[23:0];
                    OFS_RESISTOR: resistor_reg <= reg_wdata[15:0];
                    OFS_VREF:     vref_reg     <= reg_wdata[15:0];
                    OFS_VMAX:     vmax_reg     <= reg_wdata[15:0];
                    OFS_ACQ:      acq_reg      <= reg_wdata[15:0];
                    OFS_RAW:      raw_reg      <= reg_wdata[11:0];
                    default:      ;
                endcase
            end
        end
    end

    // One-cycle start strobe from a write of the start bit
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            start_reg <= 1'b0;
        end else begin
            start_reg <= reg_wr && (reg_addr == OFS_CTRL) && reg_wdata[CTRL_START_BIT];
        end
    end

    // One comparator per prescaler range; exactly the nominal value keeps that range
    for (genvar g = 0; g < RANGE_CNT; g++) begin : g_range_fit
        assign fits_range[g] = (vmax_reg <= 16'(RANGE_TOP_MV >> g));
    end

    // Range from the maximum magnitude; polarity plays no part
    always_comb begin
        range_next = RANGE_16V;
        over_next  = !fits_range[0];
        for (int k = 0; k < RANGE_CNT; k++) begin
            if (fits_range[k]) begin
                range_next = 3'(k);
            end
        end
        if (ctrl_reg.on_temp_pad) begin
            range_next = fits_range[RANGE_4V] ? RANGE_4V : RANGE_16V;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            range_reg      <= RANGE_16V;
            over_reg       <= 1'b0;
            prescale_range <= RANGE_16V;
        end else begin
            range_reg      <= range_next;
            over_reg       <= over_next;
            prescale_range <= range_reg;
        end
    end

    // Flag acquisition settings too short for prescaler settling
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            acq_short_reg <= 1'b0;
        end else begin
            acq_short_reg <= (acq_reg < 16'(SETTLE_CYC));
        end
    end

    // Numerator and denominator; code = num / den in the 12-bit domain
    always_comb begin
        num_next = '0;
        den_next = '0;
        case (ctrl_reg.mon)
            ATS_MON_VOLT: begin
                // mV x 5/32 x 2^range x 4096 / Vref(mV)
                num_next = ((NUM_W'(user_thr_reg[15:0]) * NUM_W'(SF_NUM)) << range_reg)
                           << (CODE_LOG2 - SF_DEN_LOG2);
                den_next = DEN_W'(vref_reg);
            end
            ATS_MON_CURR, ATS_MON_DIFF: begin
                // mA x milliohm x 10 gives uV
                num_next = NUM_W'(user_thr_reg[15:0]) * NUM_W'(resistor_reg)
                           * NUM_W'(CUR_GAIN * CODE_LEVELS);
                den_next = DEN_W'(vref_reg) * DEN_W'(MV_PER_V);
            end
            ATS_MON_TEMP: begin
                // Kelvin x diode constant x 12.5, held in mV at Q16
                num_next = (NUM_W'(user_thr_reg[15:0]) * NUM_W'(TEMP_KG_Q16))
                           << CODE_LOG2;
                den_next = DEN_W'(vref_reg) << TEMP_Q_LOG2;
            end
            default: begin
                num_next = '0;
                den_next = '0;
            end
        endcase
    end

    assign trial = NUM_W'(den_reg) << bit_reg;

    // Quotient would not fit in 12 bits
    assign sat_hit = (num_reg >= {4'h0, den_reg, 12'h000});

    // Threshold sequencer: restoring division, one quotient bit a cycle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= ATS_ST_IDLE;
            num_reg   <= '0;
            den_reg   <= '0;
            quot_reg  <= 12'h000;
            bit_reg      <= 4'h0;
            res_hold_reg <= ATS_RES_12;
        end else begin
            case (state_reg)
                ATS_ST_IDLE: begin
                    if (start_reg) begin
                        quot_reg  <= 12'h000;
                        state_reg <= ATS_ST_PREP;
                    end
                end
                ATS_ST_PREP: begin
                    // Operands and resolution are frozen here so later writes cannot skew the result
                    num_reg      <= num_next;
                    den_reg      <= den_next;
                    res_hold_reg <= ctrl_reg.res;
                    state_reg    <= ATS_ST_CHECK;
                end
                ATS_ST_CHECK: begin
                    if (sat_hit) begin
                        quot_reg  <= CODE_FULL;
                        state_reg <= ATS_ST_FINISH;
                    end else begin
                        bit_reg   <= 4'(CODE_W - 1);
                        state_reg <= ATS_ST_DIVIDE;
                    end
                end
                ATS_ST_DIVIDE: begin
                    if (num_reg >= trial) begin
                        num_reg           <= num_reg - trial;
                        quot_reg[bit_reg] <= 1'b1;
                    end
                    if (bit_reg == 4'h0) begin
                        state_reg <= ATS_ST_FINISH;
                    end else begin
                        bit_reg <= bit_reg - 4'h1;
                    end
                end
                ATS_ST_FINISH: begin
                    state_reg <= ATS_ST_IDLE;
                end
                default: state_reg <= ATS_ST_IDLE;
            endcase
        end
    end

    // Status flags; starts are only taken in idle, so a finish and a start never meet
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            sat_reg  <= 1'b0;
        end else if (state_reg == ATS_ST_IDLE && start_reg) begin
            busy_reg <= 1'b1;
            done_reg <= 1'b0;
            sat_reg  <= 1'b0;
        end else if (state_reg == ATS_ST_CHECK && sat_hit) begin
            sat_reg <= 1'b1;
        end else if (state_reg == ATS_ST_FINISH) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
        end
    end

    // Published threshold, masked with the resolution captured with the operands
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            threshold_code  <= 12'h000;
            threshold_valid <= 1'b0;
        end else if (state_reg == ATS_ST_FINISH) begin
            threshold_code  <= ats_mask(quot_reg, res_hold_reg);
            threshold_valid <= 1'b1;
        end else if (start_reg && state_reg == ATS_ST_IDLE) begin
            threshold_valid <= 1'b0;
        end
    end

    // Converter clock enable, divider a multiple of four and never below the minimum
    // Divider request in system clock cycles
    assign div_req = {2'h0, ctrl_reg.div_mult, 2'h0};

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            div_eff_reg <= 8'(ADC_DIV_MIN);
            div_cnt_reg <= 8'h00;
            adc_clk_en  <= 1'b0;
        end else begin
            div_eff_reg <= (div_req < 8'(ADC_DIV_MIN)) ? 8'(ADC_DIV_MIN) : div_req;
            // A shortened divider ends the current period at once rather than wrapping
            if (div_cnt_reg >= div_eff_reg - 8'h01) begin
                div_cnt_reg <= 8'h00;
                adc_clk_en  <= 1'b1;
            end else begin
                div_cnt_reg <= div_cnt_reg + 8'h01;
                adc_clk_en  <= 1'b0;
            end
        end
    end

    // Raw temperature result in quarter kelvin
    always_comb begin
        case (ctrl_reg.res)
            ATS_RES_10: kelvin_q = {2'h0, raw_reg[9:0], 2'h0};
            ATS_RES_8:  kelvin_q = {2'h0, raw_reg[7:0], 4'h0};
            default:    kelvin_q = {2'h0, raw_reg};
        endcase
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                OFS_CTRL:      reg_rdata <= {16'h0000, ctrl_reg.div_mult, 6'h00, ctrl_reg.on_temp_pad,
                                             ctrl_reg.neg_polarity, ctrl_reg.res, ctrl_reg.mon};
                OFS_USER_THR:  reg_rdata <= {8'h00, user_thr_reg};
                OFS_RESISTOR:  reg_rdata <= {16'h0000, resistor_reg};
                OFS_VREF:      reg_rdata <= {16'h0000, vref_reg};
                OFS_VMAX:      reg_rdata <= {16'h0000, vmax_reg};
                OFS_ACQ:       reg_rdata <= {16'h0000, acq_reg};
                OFS_STATUS:    reg_rdata <= {24'h000000, range_reg, acq_short_reg, over_reg,
                                             sat_reg, done_reg, busy_reg};
                OFS_THRESHOLD: reg_rdata <= {20'h00000, threshold_code};
                OFS_ADC_DIV:   reg_rdata <= {24'h000000, div_eff_reg};
                OFS_RAW:       reg_rdata <= {18'h00000, kelvin_q};
                default:       reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule : ats_threshold

// *** test/ats_monitor_model.sv ***
`timescale 1ns/1ps
module ats_monitor_model
    import ats_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic [11:0] threshold_code,
    input  wire logic        threshold_valid,
    input  wire logic        adc_clk_en,
    input  wire logic [11:0] raw_in,
    output logic             over_flag,
    output logic      [15:0] n_conv,
    output logic      [15:0] acq_cycles
);
    // Acquisition time given to the device covers prescaler settling
    assign acq_cycles = 16'(SETTLE_CYC);
    // Compares one raw result per converter clock against the threshold
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            n_conv    <= 16'h0000;
            over_flag <= 1'b0;
        end else if (adc_clk_en) begin
            n_conv    <= n_conv + 16'h0001;
            over_flag <= threshold_valid && (raw_in > threshold_code);
        end
    end
endmodule : ats_monitor_model

// *** test/ats_threshold_props.sv ***
`timescale 1ns/1ps
module ats_threshold_chk
    import ats_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [11:0] threshold_code,
    input wire logic        threshold_valid,
    input wire logic [2:0]  prescale_range,
    input wire logic        adc_clk_en
);
    ats_res_t   res_reg;
    logic       pad_reg;
    logic [7:0] gap_reg;
    logic       armed_reg;
    logic       start_w;
    assign start_w = reg_wr && reg_addr == OFS_CTRL && reg_wdata[CTRL_START_BIT];
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            res_reg <= ATS_RES_12;
            pad_reg <= 1'b0;
        end else if (reg_wr && reg_addr == OFS_CTRL) begin
            res_reg <= ats_res_t'(reg_wdata[3:2]);
            pad_reg <= reg_wdata[5];
        end
    end
    // Cycles since the last converter clock enable
    always_ff @(posedge clk_sys) begin
        if (sys_rst || adc_clk_en) begin
            gap_reg <= 8'h00;
        end else if (gap_reg != 8'hFF) begin
            gap_reg <= gap_reg + 8'h01;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            armed_reg <= 1'b0;
        end else if (adc_clk_en) begin
            armed_reg <= 1'b1;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    AST_START_DROP: assert property (start_w && threshold_valid |-> ##[1:3] !threshold_valid)
        else $error("valid not cleared after start");
    AST_RESULT_TIME: assert property (start_w && threshold_valid |-> ##[4:20] $rose(threshold_valid))
        else $error("result late");
    AST_MASK_10: assert property ($rose(threshold_valid) && res_reg == ATS_RES_10 |-> threshold_code[1:0] == 2'h0)
        else $error("10 bit mask broken");
    AST_MASK_8: assert property ($rose(threshold_valid) && res_reg == ATS_RES_8 |-> threshold_code[3:0] == 4'h0)
        else $error("8 bit mask broken");
    AST_CODE_HOLD: assert property (threshold_valid && $past(threshold_valid) |-> $stable(threshold_code))
        else $error("code changed while valid");
    AST_PAD_RANGE: assert property (pad_reg && $past(pad_reg, 3) |->
        prescale_range == RANGE_4V || prescale_range == RANGE_16V)
        else $error("bad range on temperature pad");
    AST_ADC_GAP: assert property (adc_clk_en && armed_reg |-> gap_reg >= 8'h1B)
        else $error("converter clock too fast");
    AST_ADC_PULSE: assert property (adc_clk_en |=> !adc_clk_en)
        else $error("enable longer than one cycle");
endmodule : ats_threshold_chk
bind ats_threshold ats_threshold_chk i_ats_threshold_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .threshold_code(threshold_code), .threshold_valid(threshold_valid), .prescale_range(prescale_range),
    .adc_clk_en(adc_clk_en));

// *** test/test_ats_threshold.sv ***
`timescale 1ns/1ps
module test_ats_threshold
    import ats_pkg::*;
;
    logic        clk_sys, sys_rst, reg_wr, reg_rd, threshold_valid, adc_clk_en, over_flag;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [11:0] threshold_code, raw_in;
    logic [2:0]  prescale_range;
    logic [15:0] n_conv, acq_cycles;
    int          miscompares, n_tests;
    // Register accesses are paced to the 10 MHz configuration rate
    localparam int CFG_GAP = SYS_CLK_HZ / ADC_CLK_MAX_HZ;
    ats_threshold i_ats_threshold (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .threshold_code(threshold_code), .threshold_valid(threshold_valid),
        .prescale_range(prescale_range), .adc_clk_en(adc_clk_en));
    ats_monitor_model i_ats_monitor_model (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .threshold_code(threshold_code), .threshold_valid(threshold_valid), .adc_clk_en(adc_clk_en),
        .raw_in(raw_in), .over_flag(over_flag), .n_conv(n_conv), .acq_cycles(acq_cycles));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        repeat (CFG_GAP) @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        repeat (CFG_GAP) @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask : rd_chk
    // Starts a computation and waits a bounded time for its result
    task automatic run(input logic [31:0] ctrl, input logic [11:0] exp);
        int i;
        wr(OFS_CTRL, ctrl | 32'h0000_0100);
        repeat (3) @(posedge clk_sys);
        for (i = 0; i < 40 && threshold_valid !== 1'b1; i++) @(posedge clk_sys);
        #1 check({20'h0, threshold_code}, {20'h0, exp});
        check({31'h0, threshold_valid}, 32'h1);
        rd_chk(OFS_THRESHOLD, {20'h0, exp});
    endtask : run
    task automatic rng(input logic [31:0] ctrl, input logic [15:0] vmax, input logic [2:0] exp);
        wr(OFS_CTRL, ctrl);
        wr(OFS_VMAX, {16'h0, vmax});
        repeat (4) @(posedge clk_sys);
        #1 check({29'h0, prescale_range}, {29'h0, exp});
    endtask : rng
    task automatic count_conv(input int span);
        logic [15:0] n0;
        @(posedge clk_sys);
        #1 n0 = n_conv;
        repeat (span) @(posedge clk_sys);
        #1 check({16'h0, n_conv - n0}, 32'h0A);
    endtask : count_conv
    task automatic t_reset_vals;
        rd_chk(OFS_CTRL, 32'h0);
        rd_chk(OFS_VREF, 32'h0A00);
        rd_chk(OFS_VMAX, 32'h3E80);
        rd_chk(OFS_ADC_DIV, 32'h1C);
        rd_chk(8'hFC, 32'h0);
        rd_chk(OFS_STATUS, 32'h0);
        wr(OFS_ACQ, {16'h0, acq_cycles});
        rd_chk(OFS_ACQ, 32'h09C4);
    endtask : t_reset_vals
    task automatic t_volt;
        wr(OFS_USER_THR, 32'h03E8);
        run(32'h0, 12'h0FA);
        run(32'h4, 12'h0F8);
        run(32'h8, 12'h0F0);
        run(32'hC, 12'h0FA);
    endtask : t_volt
    task automatic t_range;
        rng(32'h0, 16'h07D0, 3'h3);
        rng(32'h0, 16'h07D1, 3'h2);
        rng(32'h10, 16'h07D0, 3'h3);
        rng(32'h0, 16'h007D, 3'h7);
        rng(32'h0, 16'h007E, 3'h6);
        rng(32'h0, 16'h07D0, 3'h3);
        run(32'h0, 12'h7D0);
        wr(OFS_USER_THR, 32'h1388);
        run(32'h0, 12'hFFF);
        run(32'h8, 12'hFF0);
        rd_chk(OFS_STATUS, 32'h66);
    endtask : t_range
    task automatic t_pad;
        rng(32'h20, 16'h0FA0, 3'h2);
        rng(32'h20, 16'h0FA1, 3'h0);
        rng(32'h20, 16'h07D0, 3'h2);
        rng(32'h0, 16'h3E80, 3'h0);
        rng(32'h0, 16'h3E81, 3'h0);
        rd_chk(OFS_STATUS, 32'h0E);
    endtask : t_pad
    task automatic t_curr_temp;
        wr(OFS_USER_THR, 32'h0064);
        wr(OFS_RESISTOR, 32'h0032);
        run(32'h1, 12'h050);
        run(32'h2, 12'h050);
        wr(OFS_USER_THR, 32'h012C);
        run(32'h3, 12'h078);
        raw_in <= 12'h100;
        repeat (60) @(posedge clk_sys);
        #1 check({31'h0, over_flag}, 32'h1);
        raw_in <= 12'h010;
        repeat (60) @(posedge clk_sys);
        #1 check({31'h0, over_flag}, 32'h0);
    endtask : t_curr_temp
    task automatic t_raw;
        wr(OFS_CTRL, 32'h3);
        wr(OFS_RAW, 32'h012A);
        rd_chk(OFS_RAW, 32'h012A);
        wr(OFS_CTRL, 32'h7);
        rd_chk(OFS_RAW, 32'h04A8);
        wr(OFS_RAW, 32'h004A);
        wr(OFS_CTRL, 32'hB);
        rd_chk(OFS_RAW, 32'h04A0);
    endtask : t_raw
    task automatic t_adc;
        count_conv(280);
        wr(OFS_CTRL, 32'h8000);
        rd_chk(OFS_ADC_DIV, 32'h20);
        repeat (40) @(posedge clk_sys);
        count_conv(320);
        wr(OFS_CTRL, 32'h1000);
        rd_chk(OFS_ADC_DIV, 32'h1C);
    endtask : t_adc
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #200000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        sys_rst   = 1'b1;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0;
        raw_in    = 12'h000;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset_vals();
        t_volt();
        t_range();
        t_pad();
        t_curr_temp();
        t_raw();
        t_adc();
        report_and_stop();
    end
endmodule : test_ats_threshold
